//--- pin_select_pkg.sv
// Constants and types shared by the pin select map and its field banks.
// Assumes a 12-bit AXI4-Lite byte address space with 32-bit data.
package pin_select_pkg;

    // Select field layout.
    localparam int          FIELD_W     = 4;
    localparam int          FIELD_LSB   = 0;
    localparam int          FIELD_MSB   = 3;
    localparam logic [3:0]  FIELD_RESET = 4'h0;

    // Population of the map.
    localparam int NUM_PERIPH_IN = 8;
    localparam int NUM_PINS      = 16;
    localparam int NUM_FUNCS     = 16;
    localparam int IN_IDX_W      = 3;
    localparam int OUT_IDX_W     = 4;

    // Output select value that leaves a pin undriven.
    localparam logic [3:0] FUNC_NONE = 4'h0;

    // Register map, byte addresses.
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] IN_SEL_BASE     = 12'h000;
    localparam logic [11:0] IN_SPAN_MASK    = 12'h01F;
    localparam logic [11:0] OUT_SEL_BASE    = 12'h040;
    localparam logic [11:0] OUT_SPAN_MASK   = 12'h03F;
    localparam logic [11:0] CFG_CTRL_OFFSET = 12'h080;

    // Chip configuration control fields.
    localparam int   LOCK_BIT   = 13;
    localparam logic LOCK_RESET = 1'b0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read channel sequencer.
    typedef enum logic [3:0] {
        RD_IDLE  = 4'h1,
        RD_FETCH = 4'h2,
        RD_LOAD  = 4'h4,
        RD_RESP  = 4'h8
    } rd_state_t;

endpackage

//--- select_field_bank.sv
// Bank of select fields with one write port and one registered read port.
// Assumes writes are pre-qualified by the caller; all fields also appear
// flat on fields for the routing muxes.
module select_field_bank #(
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    // Clock and reset
    input  wire logic                                   sys_clk,
    input  wire logic                                   resetn,
    // Write port
    input  wire logic                                   wrEn,
    input  wire logic [IDX_W-1:0]                       wrIdx,
    input  wire logic [pin_select_pkg::FIELD_W-1:0]     wrData,
    // Read port
    input  wire logic [IDX_W-1:0]                       rdIdx,
    output logic      [pin_select_pkg::FIELD_W-1:0]     rdData,
    // All fields
    output logic      [DEPTH*pin_select_pkg::FIELD_W-1:0] fields
);

    logic [pin_select_pkg::FIELD_W-1:0] mem_reg  [DEPTH];
    logic [pin_select_pkg::FIELD_W-1:0] mem_next [DEPTH];
    logic [pin_select_pkg::FIELD_W-1:0] rdData_reg;
    logic [pin_select_pkg::FIELD_W-1:0] rdData_next;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wrEn) begin
            mem_next[wrIdx] = wrData;
        end
        rdData_next = mem_reg[rdIdx];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= pin_select_pkg::FIELD_RESET; // see [R5]
            end
            rdData_reg <= pin_select_pkg::FIELD_RESET;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rdData_reg <= rdData_next;
        end
    end

    assign rdData = rdData_reg;

    for (genvar g = 0; g < DEPTH; g++) begin : gFlat
        assign fields[g*pin_select_pkg::FIELD_W +: pin_select_pkg::FIELD_W]
            = mem_reg[g];
    end

endmodule

//--- pin_select_map.sv
// Register-controlled pin remapping with an AXI4-Lite register slave.
// Assumes device pins are asynchronous to sys_clk and that peripheral
// outputs come from logic clocked by sys_clk.
//
// Contract
// [R1] Input select field picks pin for peripheral input.
// [R2] Output select field picks function driving a pin.
// [R3] Bits 31 to 4 read zero, ignore writes.
// [R4] Select writes take effect only while unlocked.
// [R5] Fields reset to zero and read back.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module pin_select_map (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device pins
    input  wire logic [15:0] pinIn,
    output logic      [15:0] pinOut,
    output logic      [15:0] pinDriveN,
    // Peripheral side
    input  wire logic [15:0] periphOut,
    output logic      [7:0]  periphIn
);

    localparam int FW = pin_select_pkg::FIELD_W;
    localparam int NI = pin_select_pkg::NUM_PERIPH_IN;
    localparam int NP = pin_select_pkg::NUM_PINS;

    // Write channel state.
    logic        awHeld_reg, awHeld_next;
    logic        wHeld_reg, wHeld_next;
    logic [11:0] awAddr_reg, awAddr_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0]  wStrb_reg, wStrb_next;
    logic        awReady_reg, awReady_next;
    logic        wReady_reg, wReady_next;
    logic        bValid_reg, bValid_next;
    logic [1:0]  bResp_reg, bResp_next;
    logic        lock_reg, lock_next;

    // Read channel state.
    pin_select_pkg::rd_state_t rdState_reg, rdState_next;
    logic [11:0] arAddr_reg, arAddr_next;
    logic        arReady_reg, arReady_next;
    logic        rValid_reg, rValid_next;
    logic [31:0] rData_reg, rData_next;
    logic [1:0]  rResp_reg, rResp_next;

    // Routing state.
    logic [NP-1:0] pinSync1_reg, pinSync2_reg;
    logic [NI-1:0] periphIn_reg, periphIn_next;
    logic [NP-1:0] pinOut_reg, pinOut_next;
    logic [NP-1:0] pinDriveN_reg, pinDriveN_next;

    // Field banks.
    logic [NI*FW-1:0] inFields;
    logic [NP*FW-1:0] outFields;
    logic [FW-1:0]    inRdData, outRdData;

    // Address decode.
    logic doWrite;
    logic wrAligned, wrHitIn, wrHitOut, wrHitCfg, wrMapped;
    logic rdAligned, rdHitIn, rdHitOut, rdHitCfg;
    logic inWrEn, outWrEn;
    logic awTake, wTake, arTake;

    assign awTake = s_axi_awvalid && awReady_reg;
    assign wTake  = s_axi_wvalid && wReady_reg;
    assign arTake = s_axi_arvalid && arReady_reg;
    assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

    assign wrAligned = (awAddr_reg[1:0] == 2'h0);
    assign wrHitIn  = wrAligned && ((awAddr_reg & ~pin_select_pkg::IN_SPAN_MASK)
                      == pin_select_pkg::IN_SEL_BASE);
    assign wrHitOut = wrAligned && ((awAddr_reg & ~pin_select_pkg::OUT_SPAN_MASK)
                      == pin_select_pkg::OUT_SEL_BASE);
    assign wrHitCfg = (awAddr_reg == pin_select_pkg::CFG_CTRL_OFFSET);
    assign wrMapped = wrHitIn || wrHitOut || wrHitCfg;

    assign rdAligned = (arAddr_reg[1:0] == 2'h0);
    assign rdHitIn  = rdAligned && ((arAddr_reg & ~pin_select_pkg::IN_SPAN_MASK)
                      == pin_select_pkg::IN_SEL_BASE);
    assign rdHitOut = rdAligned && ((arAddr_reg & ~pin_select_pkg::OUT_SPAN_MASK)
                      == pin_select_pkg::OUT_SEL_BASE);
    assign rdHitCfg = (arAddr_reg == pin_select_pkg::CFG_CTRL_OFFSET);

    // Only byte lane 0 carries a field; the upper lanes are dropped.
    assign inWrEn  = doWrite && wrHitIn && wStrb_reg[0] && !lock_reg;  // see [R4]
    assign outWrEn = doWrite && wrHitOut && wStrb_reg[0] && !lock_reg; // see [R4]

    select_field_bank #(
        .DEPTH (NI),
        .IDX_W (pin_select_pkg::IN_IDX_W)
    ) inBank (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wrEn    (inWrEn),
        .wrIdx   (awAddr_reg[pin_select_pkg::IN_IDX_W+1:2]),
        .wrData  (wData_reg[pin_select_pkg::FIELD_MSB:pin_select_pkg::FIELD_LSB]), // see [R1]
        .rdIdx   (arAddr_reg[pin_select_pkg::IN_IDX_W+1:2]),
        .rdData  (inRdData),
        .fields  (inFields)
    );

    select_field_bank #(
        .DEPTH (NP),
        .IDX_W (pin_select_pkg::OUT_IDX_W)
    ) outBank (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wrEn    (outWrEn),
        .wrIdx   (awAddr_reg[pin_select_pkg::OUT_IDX_W+1:2]),
        .wrData  (wData_reg[pin_select_pkg::FIELD_MSB:pin_select_pkg::FIELD_LSB]), // see [R2]
        .rdIdx   (arAddr_reg[pin_select_pkg::OUT_IDX_W+1:2]),
        .rdData  (outRdData),
        .fields  (outFields)
    );

    // Write channel: address and data are taken in either order.
    always_comb begin
        awHeld_next = awHeld_reg;
        wHeld_next  = wHeld_reg;
        awAddr_next = awAddr_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next  = bResp_reg;
        lock_next   = lock_reg;
        if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = wrMapped ? pin_select_pkg::RESP_OKAY
                                   : pin_select_pkg::RESP_SLVERR;
            if (wrHitCfg && wStrb_reg[1]) begin
                lock_next = wData_reg[pin_select_pkg::LOCK_BIT];
            end
        end
        if (awTake) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (wTake) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        awReady_next = !awHeld_next;
        wReady_next  = !wHeld_next;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_reg  <= 1'b0;
            wHeld_reg   <= 1'b0;
            awAddr_reg  <= 12'h000;
            wData_reg   <= 32'h0000_0000;
            wStrb_reg   <= 4'h0;
            awReady_reg <= 1'b0;
            wReady_reg  <= 1'b0;
            bValid_reg  <= 1'b0;
            bResp_reg   <= pin_select_pkg::RESP_OKAY;
            lock_reg    <= pin_select_pkg::LOCK_RESET;
        end else begin
            awHeld_reg  <= awHeld_next;
            wHeld_reg   <= wHeld_next;
            awAddr_reg  <= awAddr_next;
            wData_reg   <= wData_next;
            wStrb_reg   <= wStrb_next;
            awReady_reg <= awReady_next;
            wReady_reg  <= wReady_next;
            bValid_reg  <= bValid_next;
            bResp_reg   <= bResp_next;
            lock_reg    <= lock_next;
        end
    end

    // Read channel: the banks need one cycle before the data can be loaded.
    always_comb begin
        rdState_next = rdState_reg;
        arAddr_next  = arAddr_reg;
        rValid_next  = rValid_reg;
        rData_next   = rData_reg;
        rResp_next   = rResp_reg;
        case (rdState_reg)
            pin_select_pkg::RD_IDLE: begin
                if (arTake) begin
                    arAddr_next  = s_axi_araddr;
                    rdState_next = pin_select_pkg::RD_FETCH;
                end
            end
            pin_select_pkg::RD_FETCH: begin
                rdState_next = pin_select_pkg::RD_LOAD;
            end
            pin_select_pkg::RD_LOAD: begin
                rData_next  = 32'h0000_0000; // see [R3]
                rResp_next  = pin_select_pkg::RESP_OKAY;
                rValid_next = 1'b1;
                if (rdHitIn) begin
                    rData_next[pin_select_pkg::FIELD_MSB:0] = inRdData;  // see [R5]
                end else if (rdHitOut) begin
                    rData_next[pin_select_pkg::FIELD_MSB:0] = outRdData; // see [R5]
                end else if (rdHitCfg) begin
                    rData_next[pin_select_pkg::LOCK_BIT] = lock_reg;
                end else begin
                    rResp_next = pin_select_pkg::RESP_SLVERR;
                end
                rdState_next = pin_select_pkg::RD_RESP;
            end
            pin_select_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    rValid_next  = 1'b0;
                    rdState_next = pin_select_pkg::RD_IDLE;
                end
            end
            default: begin
                rValid_next  = 1'b0;
                rdState_next = pin_select_pkg::RD_IDLE;
            end
        endcase
        arReady_next = (rdState_next == pin_select_pkg::RD_IDLE);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdState_reg <= pin_select_pkg::RD_IDLE;
            arAddr_reg  <= 12'h000;
            arReady_reg <= 1'b0;
            rValid_reg  <= 1'b0;
            rData_reg   <= 32'h0000_0000;
            rResp_reg   <= pin_select_pkg::RESP_OKAY;
        end else begin
            rdState_reg <= rdState_next;
            arAddr_reg  <= arAddr_next;
            arReady_reg <= arReady_next;
            rValid_reg  <= rValid_next;
            rData_reg   <= rData_next;
            rResp_reg   <= rResp_next;
        end
    end

    // Routing. Pins are synchronised before any select mux looks at them.
    always_comb begin
        for (int i = 0; i < NI; i++) begin
            periphIn_next[i] = pinSync2_reg[inFields[i*FW +: FW]]; // see [R1]
        end
        for (int n = 0; n < NP; n++) begin
            if (outFields[n*FW +: FW] == pin_select_pkg::FUNC_NONE) begin
                pinOut_next[n]    = 1'b0;
                pinDriveN_next[n] = 1'b1;
            end else begin
                pinOut_next[n]    = periphOut[outFields[n*FW +: FW]]; // see [R2]
                pinDriveN_next[n] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinSync1_reg  <= 16'h0000;
            pinSync2_reg  <= 16'h0000;
            periphIn_reg  <= 8'h00;
            pinOut_reg    <= 16'h0000;
            pinDriveN_reg <= 16'hFFFF;
        end else begin
            pinSync1_reg  <= pinIn;
            pinSync2_reg  <= pinSync1_reg;
            periphIn_reg  <= periphIn_next;
            pinOut_reg    <= pinOut_next;
            pinDriveN_reg <= pinDriveN_next;
        end
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready  = wReady_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;
    assign periphIn      = periphIn_reg;
    assign pinOut        = pinOut_reg;
    assign pinDriveN     = pinDriveN_reg;

    // Checking helpers: last input field write and whether any field was written.
    logic                               chkValid_reg;
    logic [pin_select_pkg::IN_IDX_W-1:0] chkIdx_reg;
    logic [FW-1:0]                      chkData_reg;
    logic                               anyWrite_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chkValid_reg <= 1'b0;
            chkIdx_reg   <= '0;
            chkData_reg  <= 4'h0;
            anyWrite_reg <= 1'b0;
        end else begin
            chkValid_reg <= inWrEn;
            chkIdx_reg   <= awAddr_reg[pin_select_pkg::IN_IDX_W+1:2];
            chkData_reg  <= wData_reg[FW-1:0];
            anyWrite_reg <= anyWrite_reg || inWrEn || outWrEn;
        end
    end

    AST_IN_ROUTE: assert property ( // see [R1]
        @(posedge sys_clk) disable iff (!resetn)
        (pinIn == $past(pinIn, 1)) && (pinIn == $past(pinIn, 2)) &&
        (pinIn == $past(pinIn, 3)) && (inFields == $past(inFields, 1))
        |-> periphIn_reg[0] == pinIn[inFields[3:0]])
        else $error("Peripheral input 0 does not follow its selected pin.");

    AST_OUT_ROUTE: assert property ( // see [R2]
        @(posedge sys_clk) disable iff (!resetn)
        (periphOut == $past(periphOut)) && (outFields == $past(outFields)) &&
        (outFields[3:0] != 4'h0)
        |-> (pinOut_reg[0] == periphOut[outFields[3:0]]) && !pinDriveN_reg[0])
        else $error("Pin 0 does not carry its selected function.");

    AST_UPPER_ZERO: assert property ( // see [R3]
        @(posedge sys_clk) disable iff (!resetn)
        (rdState_reg == pin_select_pkg::RD_LOAD) && (rdHitIn || rdHitOut)
        |=> s_axi_rvalid && (s_axi_rdata[31:4] == 28'h0000000))
        else $error("Select register read shows nonzero upper bits.");

    AST_LOCK_HOLDS: assert property ( // see [R4]
        @(posedge sys_clk) disable iff (!resetn)
        doWrite && lock_reg && (wrHitIn || wrHitOut)
        |=> $stable(inFields) && $stable(outFields))
        else $error("Select field changed while the map was locked.");

    AST_WRITE_LANDS: assert property ( // see [R1]
        @(posedge sys_clk) disable iff (!resetn)
        chkValid_reg |-> inFields[chkIdx_reg*FW +: FW] == chkData_reg)
        else $error("Unlocked input select write was not stored.");

    AST_RESET_ZERO: assert property ( // see [R5]
        @(posedge sys_clk) disable iff (!resetn)
        !anyWrite_reg |-> (inFields == '0) && (outFields == '0) &&
        (pinDriveN_reg == 16'hFFFF))
        else $error("Select fields not zero before any write.");

    // Address taken, bank fetch, answer load, then rvalid stands.
    AST_READ_TIMING: assert property ( // see [R5]
        @(posedge sys_clk) disable iff (!resetn)
        arTake |-> !s_axi_rvalid ##1 !s_axi_rvalid ##1 !s_axi_rvalid
        ##1 s_axi_rvalid)
        else $error("Read data did not arrive three cycles after address.");

endmodule

//--- tb.sv
// Self-checking bench for the pin select map: registers over AXI4-Lite,
// routing of pins to peripheral inputs and of functions to pins.
// Assumes pin_select_pkg and the design modules are compiled before it.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHECK(nm, ex, got) begin \
    compares++; \
    if ((got) !== (ex)) begin \
        badCount++; \
        $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
end

    logic        sys_clk;
    logic        resetn;
    logic [11:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [15:0] pinIn;
    logic [15:0] pinOut;
    logic [15:0] pinDriveN;
    logic [15:0] periphOut;
    logic [7:0]  periphIn;
    int          badCount;
    int          compares;
    logic [3:0]  wrStrb;

    pin_select_map uut (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .pinIn         (pinIn),
        .pinOut        (pinOut),
        .pinDriveN     (pinDriveN),
        .periphOut     (periphOut),
        .periphIn      (periphIn)
    );

    always #5 sys_clk = ~sys_clk;

    function automatic logic [11:0] in_addr(input int i);
        return pin_select_pkg::IN_SEL_BASE + 12'(4 * i);
    endfunction

    function automatic logic [11:0] out_addr(input int n);
        return pin_select_pkg::OUT_SEL_BASE + 12'(4 * n);
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Write and data are offered together; the response is awaited after.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        int n;
        bit awDone;
        bit wDone;
        bit bDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        bDone  = 1'b0;
        resp   = 2'h3;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= wrStrb;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100 && !bDone; n++) begin
            @(posedge sys_clk);
            if (awDone && wDone && s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                bDone = 1'b1;
            end
            if (!awDone && s_axi_awready) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        `CHECK("write completes", 1'b1, bDone)
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        bit arDone;
        bit rDone;
        arDone = 1'b0;
        rDone  = 1'b0;
        d      = 32'hFFFFFFFF;
        resp   = 2'h3;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100 && !rDone; n++) begin
            @(posedge sys_clk);
            if (arDone && s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                rDone = 1'b1;
            end
            if (!arDone && s_axi_arready) begin
                arDone = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        `CHECK("read completes", 1'b1, rDone)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] expResp);
        logic [1:0] resp;
        axi_write(a, d, resp);
        `CHECK("bresp", expResp, resp)
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                      input logic [1:0] expResp);
        logic [31:0] d;
        logic [1:0]  resp;
        axi_read(a, d, resp);
        `CHECK("rdata", ex, d)
        `CHECK("rresp", expResp, resp)
    endtask

    task automatic test_reset_values;
        `CHECK("pinDriveN", 16'hFFFF, pinDriveN)
        `CHECK("pinOut", 16'h0000, pinOut)
        `CHECK("periphIn", 8'h00, periphIn)
        for (int i = 0; i < 8; i++) rd(in_addr(i), 32'h0, 2'h0);
        for (int n = 0; n < 16; n++) rd(out_addr(n), 32'h0, 2'h0);
        rd(pin_select_pkg::CFG_CTRL_OFFSET, 32'h0, 2'h0);
        $display("test reset values done");
    endtask

    task automatic test_upper_bits;
        wr(in_addr(2), 32'hFFFFFFF6, 2'h0);
        rd(in_addr(2), 32'h00000006, 2'h0);
        wr(out_addr(4), 32'h1234567B, 2'h0);
        rd(out_addr(4), 32'h0000000B, 2'h0);
        wr(12'h0C0, 32'h0000000F, pin_select_pkg::RESP_SLVERR);
        rd(12'h0C0, 32'h0, pin_select_pkg::RESP_SLVERR);
        rd(12'h002, 32'h0, pin_select_pkg::RESP_SLVERR);
        $display("test upper bits done");
    endtask

    // Pins i and i+8 each reach peripheral input i through its select.
    task automatic test_input_route;
        int k;
        for (int i = 0; i < 8; i++) begin
            for (int h = 0; h < 2; h++) begin
                k = i + 8 * h;
                wr(in_addr(i), 32'(k), 2'h0);
                rd(in_addr(i), 32'(k), 2'h0);
                pinIn <= 16'h1 << k;
                repeat (3) @(posedge sys_clk);
                #1;
                `CHECK("periphIn high", 1'b1, periphIn[i])
                @(posedge sys_clk);
                pinIn <= ~(16'h1 << k);
                repeat (3) @(posedge sys_clk);
                #1;
                `CHECK("periphIn low", 1'b0, periphIn[i])
            end
        end
        $display("test input route done");
    endtask

    // Function 0 leaves its pin undriven; all others drive it.
    task automatic test_output_route;
        int f;
        for (int n = 0; n < 16; n++) begin
            f = 15 - n;
            wr(out_addr(n), 32'(f), 2'h0);
            periphOut <= 16'h1 << f;
            repeat (2) @(posedge sys_clk);
            #1;
            `CHECK("pinOut high", (f != 0), pinOut[n])
            `CHECK("pinDriveN", (f == 0), pinDriveN[n])
            @(posedge sys_clk);
            periphOut <= ~(16'h1 << f);
            repeat (2) @(posedge sys_clk);
            #1;
            `CHECK("pinOut low", 1'b0, pinOut[n])
        end
        $display("test output route done");
    endtask

    task automatic test_lock;
        logic [31:0] lockWord;
        lockWord = 32'h1 << pin_select_pkg::LOCK_BIT;
        wr(in_addr(0), 32'h5, 2'h0);
        wr(out_addr(3), 32'h7, 2'h0);
        wr(pin_select_pkg::CFG_CTRL_OFFSET, lockWord, 2'h0);
        rd(pin_select_pkg::CFG_CTRL_OFFSET, lockWord, 2'h0);
        wr(in_addr(0), 32'h9, 2'h0);
        wr(out_addr(3), 32'hC, 2'h0);
        rd(in_addr(0), 32'h5, 2'h0);
        rd(out_addr(3), 32'h7, 2'h0);
        wr(pin_select_pkg::CFG_CTRL_OFFSET, 32'h0, 2'h0);
        wr(in_addr(0), 32'h9, 2'h0);
        wr(out_addr(3), 32'hC, 2'h0);
        rd(in_addr(0), 32'h9, 2'h0);
        rd(out_addr(3), 32'hC, 2'h0);
        // A field write without byte lane 0 and a lock write without
        // byte lane 1 are both dropped.
        wrStrb = 4'hE;
        wr(in_addr(0), 32'h3, 2'h0);
        rd(in_addr(0), 32'h9, 2'h0);
        wrStrb = 4'h1;
        wr(pin_select_pkg::CFG_CTRL_OFFSET, lockWord, 2'h0);
        rd(pin_select_pkg::CFG_CTRL_OFFSET, 32'h0, 2'h0);
        wrStrb = 4'hF;
        $display("test lock done");
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        tally_and_finish();
    end

    initial begin
        badCount      = 0;
        compares      = 0;
        wrStrb        = 4'hF;
        sys_clk       = 1'b0;
        resetn        = 1'b0;
        s_axi_awaddr  = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        pinIn         = 16'h0000;
        periphOut     = 16'h0000;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        test_reset_values();
        test_upper_bits();
        test_input_route();
        test_output_route();
        test_lock();
        tally_and_finish();
    end
endmodule
